// *** design/mac_rx_stats.sv ***
// receive statistics slice: length-mismatch and fifo-overflow drop
// counters, plus the checksum-offload counter interrupt mask and status.
// assumes apb from logic on mclk_in, and event pulses from the receive
// datapath and the checksum-offload counters on the same clock.
// usage notes
//
// - both counters are plain binary and wrap from all ones to zero;
//   software that wants a rate must read twice and subtract.
//
// - a software write to a counter in the same cycle as an event pulse
//   keeps the written value and loses the pulse; this keeps a clear
//   by writing zero exact, at the cost of one possible missed count.
//
// - the status register is cleared by reading it, not by writing;
//   writes to it are accepted with no error and change nothing.
//
// - only the status bits that the read actually returned are cleared,
//   so a threshold event that arrives while a read is in flight
//   is never lost.
//
// - the mask gates only the interrupt pin; status bits record every
//   threshold event whatever the mask holds.
//
// - reserved mask and status bits read zero and cannot be set.
//
// - there are no wait states: pready is tied high.
//
// The APB slave port was chosen for this implementation.

`timescale 1ns/1ps
`default_nettype none

module mac_rx_stats
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [mac_rx_stats_pkg::ADDR_W-1:0] paddr_in,
    input wire logic [mac_rx_stats_pkg::DATA_W-1:0] pwdata_in,
    input wire logic [mac_rx_stats_pkg::STRB_W-1:0] pstrb_in,
    output logic [mac_rx_stats_pkg::DATA_W-1:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic length_mismatch_frame_in,
    input wire logic fifo_overflow_drop_in,
    input wire logic [mac_rx_stats_pkg::DATA_W-1:0] checksum_offload_threshold_in,
    output logic checksum_offload_irq_out
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [mac_rx_stats_pkg::DATA_W-1:0] rx_length_mismatch_count;
    logic [mac_rx_stats_pkg::DATA_W-1:0] rx_fifo_overflow_drop_count;
    logic [mac_rx_stats_pkg::DATA_W-1:0] checksum_counter_interrupt_mask;
    logic [mac_rx_stats_pkg::DATA_W-1:0] checksum_counter_interrupt_status;
    logic [mac_rx_stats_pkg::DATA_W-1:0] read_data;
    logic irq;

    // ------------------------------------------------------------
    // apb phase decode
    // ------------------------------------------------------------
    wire setup_phase;
    wire access_phase;
    wire write_access;
    wire read_access;

    // the setup cycle is where read data is captured; the access
    // cycle is where writes land and the status read clears

    assign setup_phase = psel_in && !penable_in;
    assign access_phase = psel_in && penable_in;
    assign write_access = access_phase && pwrite_in;
    assign read_access = access_phase && !pwrite_in;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire hit_length;
    wire hit_overflow;
    wire hit_mask;
    wire hit_status;
    wire hit_any;

    // the full address is compared, so aliases above the block
    // decode as unmapped and answer with an error

    assign hit_length = paddr_in == mac_rx_stats_pkg::RX_LENGTH_MISMATCH_COUNT_OFFSET;
    assign hit_overflow = paddr_in == mac_rx_stats_pkg::RX_FIFO_OVERFLOW_DROP_COUNT_OFFSET;
    assign hit_mask = paddr_in == mac_rx_stats_pkg::CHECKSUM_COUNTER_INTERRUPT_MASK_OFFSET;
    assign hit_status = paddr_in == mac_rx_stats_pkg::CHECKSUM_COUNTER_INTERRUPT_STATUS_OFFSET;
    assign hit_any = hit_length || hit_overflow || hit_mask || hit_status;

    // ------------------------------------------------------------
    // byte-lane merge
    // ------------------------------------------------------------
    wire [mac_rx_stats_pkg::DATA_W-1:0] lane_mask;

    genvar lane;
    generate
        for (lane = 0; lane < mac_rx_stats_pkg::STRB_W; lane = lane + 1)
        begin : g_lane
            assign lane_mask[lane*8 +: 8] = {8{pstrb_in[lane]}};
        end
    endgenerate

    wire [mac_rx_stats_pkg::DATA_W-1:0] length_written;
    wire [mac_rx_stats_pkg::DATA_W-1:0] overflow_written;
    wire [mac_rx_stats_pkg::DATA_W-1:0] mask_written;

    assign length_written = (rx_length_mismatch_count & ~lane_mask) | (pwdata_in & lane_mask);
    assign overflow_written = (rx_fifo_overflow_drop_count & ~lane_mask) | (pwdata_in & lane_mask);
    // reserved mask bits cannot be written
    assign mask_written = ((checksum_counter_interrupt_mask & ~lane_mask) | (pwdata_in & lane_mask))
                          & mac_rx_stats_pkg::CHECKSUM_FIELD_BITS;

    // ------------------------------------------------------------
    // counter next values
    // ------------------------------------------------------------
    wire write_length;
    wire write_overflow;
    wire write_mask;
    wire [mac_rx_stats_pkg::DATA_W-1:0] next_rx_length_mismatch_count;
    wire [mac_rx_stats_pkg::DATA_W-1:0] next_rx_fifo_overflow_drop_count;
    wire [mac_rx_stats_pkg::DATA_W-1:0] next_checksum_counter_interrupt_mask;

    // one write strobe per writable register

    assign write_length = write_access && hit_length;
    assign write_overflow = write_access && hit_overflow;
    assign write_mask = write_access && hit_mask;

    // a software write wins over a same-cycle count; the counter wraps at full scale
    assign next_rx_length_mismatch_count =
        write_length ? length_written
        : length_mismatch_frame_in ? rx_length_mismatch_count + 32'h0000_0001
        : rx_length_mismatch_count;

    assign next_rx_fifo_overflow_drop_count =
        write_overflow ? overflow_written
        : fifo_overflow_drop_in ? rx_fifo_overflow_drop_count + 32'h0000_0001
        : rx_fifo_overflow_drop_count;


    // the mask only changes under software control

    assign next_checksum_counter_interrupt_mask =
        write_mask ? mask_written : checksum_counter_interrupt_mask;

    // ------------------------------------------------------------
    // checksum-offload status: set at half and full scale, read-to-clear
    // ------------------------------------------------------------
    wire [mac_rx_stats_pkg::DATA_W-1:0] status_set;
    wire [mac_rx_stats_pkg::DATA_W-1:0] status_clear;
    wire [mac_rx_stats_pkg::DATA_W-1:0] next_checksum_counter_interrupt_status;

    // threshold pulses arrive already aligned to this clock, one bit
    // per counter, in the same layout as the mask

    // recording ignores the mask entirely
    assign status_set = checksum_offload_threshold_in & mac_rx_stats_pkg::CHECKSUM_FIELD_BITS;
    // only the bits software actually saw are cleared, so an event landing
    // between the setup and access cycles of the read is kept for next time
    assign status_clear = (read_access && hit_status) ? read_data : 32'h0000_0000;
    // set wins over clear
    assign next_checksum_counter_interrupt_status =
        (checksum_counter_interrupt_status & ~status_clear) | status_set;

    // ------------------------------------------------------------
    // interrupt gating, one mask bit per counter
    // ------------------------------------------------------------
    wire [mac_rx_stats_pkg::DATA_W-1:0] ns;
    wire [mac_rx_stats_pkg::DATA_W-1:0] nm;

    // short aliases for the next status and mask, to keep the
    // per-counter gating lines readable

    assign ns = next_checksum_counter_interrupt_status;

    assign nm = next_checksum_counter_interrupt_mask;

    // each counter has its own gate so that a mask bit affects
    // exactly one source and nothing else

    wire pend_icmp_bytes;
    wire pend_tcp_bytes;
    wire pend_udp_bytes;
    wire pend_ipv6_hdr_bytes;
    wire pend_ipv4_hdr_bytes;
    wire pend_icmp_frames;
    wire pend_tcp_frames;
    wire pend_udp_frames;
    wire pend_ipv6_hdr_frames;
    wire pend_ipv6_good;
    wire pend_ipv4_hdr_frames;
    wire pend_ipv4_good;
    wire next_irq;

    assign pend_icmp_bytes = ns[mac_rx_stats_pkg::MASK_ICMP_ERROR_BYTES]
                             && !nm[mac_rx_stats_pkg::MASK_ICMP_ERROR_BYTES];
    assign pend_tcp_bytes = ns[mac_rx_stats_pkg::MASK_TCP_ERROR_BYTES]
                            && !nm[mac_rx_stats_pkg::MASK_TCP_ERROR_BYTES];
    assign pend_udp_bytes = ns[mac_rx_stats_pkg::MASK_UDP_ERROR_BYTES]
                            && !nm[mac_rx_stats_pkg::MASK_UDP_ERROR_BYTES];
    assign pend_ipv6_hdr_bytes = ns[mac_rx_stats_pkg::MASK_IPV6_HEADER_ERROR_BYTES]
                                 && !nm[mac_rx_stats_pkg::MASK_IPV6_HEADER_ERROR_BYTES];
    assign pend_ipv4_hdr_bytes = ns[mac_rx_stats_pkg::MASK_IPV4_HEADER_ERROR_BYTES]
                                 && !nm[mac_rx_stats_pkg::MASK_IPV4_HEADER_ERROR_BYTES];
    assign pend_icmp_frames = ns[mac_rx_stats_pkg::MASK_ICMP_ERROR_FRAMES]
                              && !nm[mac_rx_stats_pkg::MASK_ICMP_ERROR_FRAMES];
    assign pend_tcp_frames = ns[mac_rx_stats_pkg::MASK_TCP_ERROR_FRAMES]
                             && !nm[mac_rx_stats_pkg::MASK_TCP_ERROR_FRAMES];
    assign pend_udp_frames = ns[mac_rx_stats_pkg::MASK_UDP_ERROR_FRAMES]
                             && !nm[mac_rx_stats_pkg::MASK_UDP_ERROR_FRAMES];
    assign pend_ipv6_hdr_frames = ns[mac_rx_stats_pkg::MASK_IPV6_HEADER_ERROR_FRAMES]
                                  && !nm[mac_rx_stats_pkg::MASK_IPV6_HEADER_ERROR_FRAMES];
    assign pend_ipv6_good = ns[mac_rx_stats_pkg::MASK_IPV6_GOOD_DATAGRAMS]
                            && !nm[mac_rx_stats_pkg::MASK_IPV6_GOOD_DATAGRAMS];
    assign pend_ipv4_hdr_frames = ns[mac_rx_stats_pkg::MASK_IPV4_HEADER_ERROR_FRAMES]
                                  && !nm[mac_rx_stats_pkg::MASK_IPV4_HEADER_ERROR_FRAMES];
    assign pend_ipv4_good = ns[mac_rx_stats_pkg::MASK_IPV4_GOOD_DATAGRAMS]
                            && !nm[mac_rx_stats_pkg::MASK_IPV4_GOOD_DATAGRAMS];


    // registered from next values so the pin follows the status with no lag
    // and the pin itself comes straight from a flop, free of glitches
    assign next_irq = pend_icmp_bytes || pend_tcp_bytes || pend_udp_bytes
                      || pend_ipv6_hdr_bytes || pend_ipv4_hdr_bytes
                      || pend_icmp_frames || pend_tcp_frames || pend_udp_frames
                      || pend_ipv6_hdr_frames || pend_ipv6_good
                      || pend_ipv4_hdr_frames || pend_ipv4_good;

    // ------------------------------------------------------------
    // read-back select
    // ------------------------------------------------------------
    wire [mac_rx_stats_pkg::DATA_W-1:0] read_select;

    // one register at most is hit, so the order of this chain is
    // only a matter of style

    // unmapped addresses read zero and flag an error in the access phase
    assign read_select =
        hit_length ? rx_length_mismatch_count
        : hit_overflow ? rx_fifo_overflow_drop_count
        : hit_mask ? checksum_counter_interrupt_mask
        : hit_status ? checksum_counter_interrupt_status
        : 32'h0000_0000;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------

    // statistics counters: reset clears both, otherwise they take
    // their next values every cycle

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            rx_length_mismatch_count <= mac_rx_stats_pkg::RX_LENGTH_MISMATCH_COUNT_RESET;
            rx_fifo_overflow_drop_count <= mac_rx_stats_pkg::RX_FIFO_OVERFLOW_DROP_COUNT_RESET;
        end
        else
        begin
            rx_length_mismatch_count <= next_rx_length_mismatch_count;
            rx_fifo_overflow_drop_count <= next_rx_fifo_overflow_drop_count;
        end
    end

    // interrupt side: mask, status and the interrupt flop share
    // one process because they always move together

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            checksum_counter_interrupt_mask <= mac_rx_stats_pkg::CHECKSUM_COUNTER_INTERRUPT_MASK_RESET;
            checksum_counter_interrupt_status <= mac_rx_stats_pkg::CHECKSUM_COUNTER_INTERRUPT_STATUS_RESET;
            irq <= 1'b0;
        end
        else
        begin
            checksum_counter_interrupt_mask <= next_checksum_counter_interrupt_mask;
            checksum_counter_interrupt_status <= next_checksum_counter_interrupt_status;
            irq <= next_irq;
        end
    end

    // read data is captured in the setup cycle so it is stable from a flop
    // through the whole access phase
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            read_data <= 32'h0000_0000;
        end
        else if (setup_phase)
        begin
            read_data <= read_select;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------

    // read data is a one-cycle-old snapshot: an event that lands in
    // the setup cycle shows on the next read instead

    assign prdata_out = read_data;

    // no wait states: every access completes in its first access cycle
    assign pready_out = 1'b1;

    // the error is a level only during the access phase

    assign pslverr_out = access_phase && !hit_any;

    // level interrupt, high while any unmasked status bit is set

    assign checksum_offload_irq_out = irq;


endmodule

`default_nettype wire

// *** design/mac_rx_stats_pkg.sv ***
// constants for the receive statistics slice: register offsets, reset
// values and the checksum-offload mask/status field positions.
// assumes a 32-bit apb register port with byte addresses.
package mac_rx_stats_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    localparam int STRB_W = DATA_W / 8;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] RX_LENGTH_MISMATCH_COUNT_OFFSET = 12'h1c8;
    localparam logic [ADDR_W-1:0] RX_FIFO_OVERFLOW_DROP_COUNT_OFFSET = 12'h1d4;
    localparam logic [ADDR_W-1:0] CHECKSUM_COUNTER_INTERRUPT_MASK_OFFSET = 12'h200;
    localparam logic [ADDR_W-1:0] CHECKSUM_COUNTER_INTERRUPT_STATUS_OFFSET = 12'h208;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] RX_LENGTH_MISMATCH_COUNT_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RX_FIFO_OVERFLOW_DROP_COUNT_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] CHECKSUM_COUNTER_INTERRUPT_MASK_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] CHECKSUM_COUNTER_INTERRUPT_STATUS_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // mask and status field positions (same layout in both)
    // ------------------------------------------------------------
    localparam int MASK_ICMP_ERROR_BYTES = 29;
    localparam int MASK_TCP_ERROR_BYTES = 27;
    localparam int MASK_UDP_ERROR_BYTES = 25;
    localparam int MASK_IPV6_HEADER_ERROR_BYTES = 22;
    localparam int MASK_IPV4_HEADER_ERROR_BYTES = 17;
    localparam int MASK_ICMP_ERROR_FRAMES = 13;
    localparam int MASK_TCP_ERROR_FRAMES = 11;
    localparam int MASK_UDP_ERROR_FRAMES = 9;
    localparam int MASK_IPV6_HEADER_ERROR_FRAMES = 6;
    localparam int MASK_IPV6_GOOD_DATAGRAMS = 5;
    localparam int MASK_IPV4_HEADER_ERROR_FRAMES = 1;
    localparam int MASK_IPV4_GOOD_DATAGRAMS = 0;

    // bits that exist; every other bit is reserved and reads zero
    localparam logic [DATA_W-1:0] CHECKSUM_FIELD_BITS = 32'h2a42_2a63;

endpackage

// *** bench/mac_rx_stats_chk.sv ***
// checker for the receive statistics slice: apb answers, read data hold,
// and the checksum-offload interrupt, judged from the top module's ports.
// assumes one clock domain and the synchronous reset of the slice.
`timescale 1ns/1ps
`default_nettype none
module mac_rx_stats_chk
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic length_mismatch_frame_in,
    input wire logic fifo_overflow_drop_in,
    input wire logic [31:0] checksum_offload_threshold_in,
    input wire logic checksum_offload_irq_out
);
    // ------------------------------------------------------------
    // decode and a shadow of the mask, rebuilt from bus writes
    // ------------------------------------------------------------
    wire acc = psel_in && penable_in;
    wire setup = psel_in && !penable_in;
    wire mapped = paddr_in inside {12'h1c8, 12'h1d4, 12'h200, 12'h208};
    wire mask_wr = acc && pwrite_in && paddr_in == 12'h200;
    wire status_rd = acc && !pwrite_in && paddr_in == 12'h208;
    wire [31:0] used_thr = checksum_offload_threshold_in & 32'h2a42_2a63;
    wire [31:0] lanes = {{8{pstrb_in[3]}}, {8{pstrb_in[2]}}, {8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
    wire irq_cause = (|used_thr) || mask_wr;
    wire irq_drop = mask_wr || status_rd;
    logic [31:0] shadow;
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            shadow <= 32'h0;
        else if (mask_wr)
            shadow <= ((shadow & ~lanes) | (pwdata_in & lanes)) & 32'h2a42_2a63;
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // a pulse during the setup cycle misses the snapshot, so it is excluded
    sequence s_clear_read;
        setup && !pwrite_in && paddr_in == 12'h208 && used_thr == 32'h0 ##1 acc && used_thr == 32'h0;
    endsequence
    a_ready_high: assert property (psel_in |-> pready_out) else $error("pready low in a transfer");
    a_err_unmapped: assert property (acc && !mapped |-> pslverr_out) else $error("no error on unmapped");
    a_err_mapped: assert property (acc && mapped |-> !pslverr_out) else $error("error on mapped address");
    a_unmapped_zero: assert property (setup && !pwrite_in && !mapped |=> prdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!setup |=> $stable(prdata_out)) else $error("read data moved");
    a_status_clears: assert property (s_clear_read |=> !checksum_offload_irq_out)
        else $error("irq stays after status read");
    a_pulse_raises: assert property ((|(used_thr & ~shadow)) && !mask_wr |=> checksum_offload_irq_out)
        else $error("unmasked pulse gave no irq");
    a_irq_cause: assert property ($rose(checksum_offload_irq_out) |-> $past(irq_cause))
        else $error("irq rose without cause");
    a_irq_drop: assert property ($fell(checksum_offload_irq_out) |-> $past(irq_drop))
        else $error("irq fell without cause");
endmodule
bind mac_rx_stats mac_rx_stats_chk mac_rx_stats_chk_inst
(
    .mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .length_mismatch_frame_in(length_mismatch_frame_in), .fifo_overflow_drop_in(fifo_overflow_drop_in),
    .checksum_offload_threshold_in(checksum_offload_threshold_in),
    .checksum_offload_irq_out(checksum_offload_irq_out)
);
`default_nettype wire

// *** bench/mac_rx_stats_tb.sv ***
// self-checking bench for the receive statistics slice.
// assumes an apb slave with no wait states and a bound checker.
`timescale 1ns/1ps
`default_nettype none
module mac_rx_stats_tb;
    typedef struct packed
    {
        logic wr;
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
        logic [31:0] exp;
        logic err;
    } row_s;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h0;
    logic [31:0] pwdata_in = 32'h0;
    logic [3:0] pstrb_in = 4'h0;
    logic length_mismatch_frame_in = 1'b0;
    logic fifo_overflow_drop_in = 1'b0;
    logic [31:0] checksum_offload_threshold_in = 32'h0;
    wire [31:0] prdata_out;
    wire pready_out;
    wire pslverr_out;
    wire checksum_offload_irq_out;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    int bits [12] = '{29, 27, 25, 22, 17, 13, 11, 9, 6, 5, 1, 0};
    logic [31:0] rd;
    logic [31:0] b;
    logic err;
    // ordinary accesses: reset values, writable bits, byte lanes, refusals
    row_s rows [15] = '{
        '{1'b0, 12'h1c8, 32'h0, 4'h0, 32'h0, 1'b0}, '{1'b0, 12'h1d4, 32'h0, 4'h0, 32'h0, 1'b0},
        '{1'b0, 12'h200, 32'h0, 4'h0, 32'h0, 1'b0}, '{1'b0, 12'h208, 32'h0, 4'h0, 32'h0, 1'b0},
        '{1'b1, 12'h200, 32'hffff_ffff, 4'hf, 32'h0, 1'b0}, '{1'b0, 12'h200, 32'h0, 4'h0, 32'h2a42_2a63, 1'b0},
        '{1'b1, 12'h200, 32'h0, 4'h2, 32'h0, 1'b0}, '{1'b0, 12'h200, 32'h0, 4'h0, 32'h2a42_0063, 1'b0},
        '{1'b1, 12'h1c8, 32'h1234_5678, 4'hf, 32'h0, 1'b0}, '{1'b1, 12'h1d4, 32'haaaa_aaf0, 4'h1, 32'h0, 1'b0},
        '{1'b1, 12'h1cc, 32'h1, 4'hf, 32'h0, 1'b1}, '{1'b0, 12'h1cc, 32'h0, 4'h0, 32'h0, 1'b1},
        '{1'b1, 12'h208, 32'hffff_ffff, 4'hf, 32'h0, 1'b0}, '{1'b0, 12'h208, 32'h0, 4'h0, 32'h0, 1'b0},
        '{1'b1, 12'h200, 32'h0, 4'hf, 32'h0, 1'b0}};
    mac_rx_stats mac_rx_stats_inst
    (
        .mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .length_mismatch_frame_in(length_mismatch_frame_in), .fifo_overflow_drop_in(fifo_overflow_drop_in),
        .checksum_offload_threshold_in(checksum_offload_threshold_in),
        .checksum_offload_irq_out(checksum_offload_irq_out)
    );
    always #4 mclk_in = ~mclk_in;
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge mclk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        pstrb_in <= s;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        @(posedge mclk_in);
        while (pready_out !== 1'b1)
            @(posedge mclk_in);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0, 4'h0);
        check(name, exp, rd);
    endtask
    // the levels stand for n cycles, so n back-to-back events
    task automatic pulse(input logic lm, input logic fo, input logic [31:0] th, input int n);
        @(posedge mclk_in);
        length_mismatch_frame_in <= lm;
        fifo_overflow_drop_in <= fo;
        checksum_offload_threshold_in <= th;
        repeat (n) @(posedge mclk_in);
        length_mismatch_frame_in <= 1'b0;
        fifo_overflow_drop_in <= 1'b0;
        checksum_offload_threshold_in <= 32'h0;
    endtask
    task automatic irq_is(input logic e);
        #1;
        check("irq", {31'h0, e}, {31'h0, checksum_offload_irq_out});
    endtask
    always @(posedge mclk_in)
    begin
        cycles++;
        if (cycles > 5000)
        begin
            mismatches++;
            test_done();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge mclk_in);
        rst_in <= 1'b0;
        foreach (rows[i])
        begin
            apb(rows[i].wr, rows[i].addr, rows[i].data, rows[i].strb);
            if (!rows[i].wr)
                check("row rdata", rows[i].exp, rd);
            check("row slverr", {31'h0, rows[i].err}, {31'h0, err});
        end
        pulse(1'b1, 1'b1, 32'h0, 3);
        rdchk(12'h1c8, 32'h1234_567b, "length count");
        rdchk(12'h1d4, 32'h0000_00f3, "overflow count");
        apb(1'b1, 12'h1c8, 32'hffff_ffff, 4'hf);
        pulse(1'b1, 1'b0, 32'h0, 1);
        rdchk(12'h1c8, 32'h0, "length wrap");
        foreach (bits[i])
        begin
            b = 32'h1 << bits[i];
            apb(1'b1, 12'h200, b, 4'hf);
            pulse(1'b0, 1'b0, b, 1);
            irq_is(1'b0);
            apb(1'b1, 12'h200, 32'h0, 4'hf);
            irq_is(1'b1);
            rdchk(12'h208, b, "status");
            irq_is(1'b0);
            pulse(1'b0, 1'b0, b, 1);
            irq_is(1'b1);
            rdchk(12'h208, b, "status again");
            rdchk(12'h208, 32'h0, "status cleared");
        end
        pulse(1'b0, 1'b0, 32'h4, 1);
        irq_is(1'b0);
        rdchk(12'h208, 32'h0, "reserved status");
        // a second reset in mid-run must bring the irq, the mask, the length count and the status back
        apb(1'b1, 12'h200, 32'hffff_ffff, 4'hf);
        pulse(1'b1, 1'b0, 32'h1, 2);
        rst_in <= 1'b1;
        repeat (12) @(posedge mclk_in);
        rst_in <= 1'b0;
        irq_is(1'b0);
        rdchk(12'h200, 32'h0, "mask after reset");
        rdchk(12'h1c8, 32'h0, "length after reset");
        rdchk(12'h208, 32'h0, "status after reset");
        test_done();
    end
endmodule
`default_nettype wire
